// >>> bench/onoff_switch_cycle_controller_test.sv
`timescale 1ns/1ps
`include "oscc_cfg.svh"
module onoff_switch_cycle_controller_test
   import oscc_pkg::*;
   ;
   logic            aclk, aresetn, cl, lu, ra, su, en, gate, mds, irq;
   logic            gate_q, mds_q, awready, wready, bvalid, arready, rvalid;
   logic            awvalid, wvalid, bready, arvalid, rready;
   logic [1:0]      fb_mode, bresp, rresp, r;
   logic [11:0]     awaddr, araddr;
   logic [31:0]     wdata, rdata, d;
   oscc_cap_t       cap;
   oscc_sense_t     sense;
   oscc_limit_sel_t lsel;
   int              bad_count, cmp_count, n_on, n0;
   time             t0;

   assign sense = {cl, mds, lu, ra, su};

   oscc_ctrl #(.RESTART_CYCLES(200)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .feedback_line_sense_pin(en),
      .sense(sense), .supply_capacitor_pin(cap), .gate(gate),
      .limit_sel(lsel), .max_duty_signal(mds), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready)
   );
   oscc_fb_model u_fb (
      .aclk(aclk), .aresetn(aresetn), .gate(gate), .mode(fb_mode), .en(en)
   );

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      gate_q <= gate;
      mds_q  <= mds;
      if (!aresetn)
         n_on <= 0;
      else if (gate && !gate_q)
         n_on <= n_on + 1;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      if (bad_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic hang();
      bad_count++;
      $display("Error at %0t: wait timed out", $time);
      report_and_stop();
   endtask

   // Leading edge keeps a new request off the edge that ended the last one
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      {awvalid, wvalid, bready} <= 3'h7;
      for (i = 0; i < 100 && !bvalid; i++) begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      if (!bvalid)
         hang();
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [11:0] a);
      int i;
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      for (i = 0; i < 100 && !rvalid; i++) begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end
      if (!rvalid)
         hang();
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic cyc(input int n);
      int k;
      int t;
      k = 0;
      for (t = 0; t < 1000 * n && k < n; t++) begin
         @(posedge aclk);
         if (mds && !mds_q)
            k++;
      end
      if (k < n)
         hang();
   endtask

   task automatic duty_end();
      int i;
      for (i = 0; i < 800 && mds; i++)
         @(posedge aclk);
      if (mds)
         hang();
   endtask

   task automatic t_reset();
      check(gate, 1'b0);
      check(lsel, {OSCC_CAP_SMALL, OSCC_LIM_STD});
      axi_rd(`OSCC_CTRL_ADDR);
      check(d, `OSCC_CTRL_RESET);
      axi_rd(`OSCC_STAT_ADDR);
      check(d[1:0], 2'd0);
      axi_rd(12'h020);
      check(r, 2'h2);
   endtask

   task automatic t_power();
      cap <= OSCC_CAP_MID;
      lu <= 1'b1;
      fb_mode <= 2'd1;
      axi_wr(`OSCC_CTRL_ADDR, 32'h1);
      n0 = n_on;
      cyc(3);
      check(n_on, n0);
      {lu, su} <= 2'b01;
      cyc(3);
      check(n_on, n0);
      {lu, ra, su} <= 3'b110;
      cyc(3);
      check(n_on > n0, 1'b1);
      axi_rd(`OSCC_STAT_ADDR);
      check({d[6:4], d[1:0]}, 5'b00101);
      {ra, cap} <= {1'b0, OSCC_CAP_LARGE};
      n0 = n_on;
      cyc(3);
      check(n_on > n0, 1'b1);
      check(lsel.cap_set, OSCC_CAP_MID);
      lu <= 1'b0;
   endtask

   task automatic t_ext();
      cyc(1);
      fb_mode <= 2'd2;
      repeat (50) @(posedge aclk);
      check(gate, 1'b1);
      duty_end();
      repeat (2) @(posedge aclk);
      check(gate, 1'b0);
      cyc(1);
      check(gate, 1'b0);
      axi_rd(`OSCC_STAT_ADDR);
      check(d[6], 1'b1);
      fb_mode <= 2'd1;
      cyc(1);
      check(gate, 1'b1);
      duty_end();
      repeat (5) @(posedge aclk);
      check(gate, 1'b1);
      cl <= 1'b1;
      repeat (3) @(posedge aclk);
      check(gate, 1'b0);
      cl <= 1'b0;
   endtask

   task automatic t_lvl();
      cyc(5);
      check(lsel.level, OSCC_LIM_PEAK);
      t0 = $time;
      cyc(1);
      check(($time - t0) / 10, 378);
      fb_mode <= 2'd2;
      cyc(3);
      check(lsel.level, OSCC_LIM_MED);
      cyc(4);
      check(lsel.level, OSCC_LIM_LOW);
      t0 = $time;
      cyc(1);
      check(($time - t0) / 10, 757);
   endtask

   // No low samples while clearing, so the event cannot set again
   task automatic t_irq();
      fb_mode <= 2'h1;
      axi_rd(`OSCC_IRQ_STAT_ADDR);
      check({d[1], irq}, 2'h2);
      axi_wr(`OSCC_IRQ_MASK_ADDR, 32'h2);
      axi_rd(`OSCC_IRQ_MASK_ADDR);
      check(d, 32'h2);
      check(irq, 1'b1);
      axi_wr(`OSCC_IRQ_STAT_ADDR, 32'h2);
      axi_rd(`OSCC_IRQ_STAT_ADDR);
      check({d[1], irq}, 2'h0);
      axi_wr(12'h020, 32'h1);
      check(r, 2'h2);
      // Every fresh pulse start is one counted cycle
      axi_rd(`OSCC_CNT_ADDR);
      check(d, n_on);
   endtask

   initial begin
      {aresetn, cl, lu, ra, su, awvalid, wvalid, bready} = '0;
      {arvalid, rready, fb_mode} = '0;
      {awaddr, araddr, wdata} = '0;
      cap = OSCC_CAP_SMALL;
      {bad_count, cmp_count, n0} = '0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_power();
      t_ext();
      t_lvl();
      t_irq();
      report_and_stop();
   end
endmodule

// >>> bench/oscc_ctrl_chk.sv
`timescale 1ns/1ps
module oscc_ctrl_chk
   import oscc_pkg::*;
#(
   parameter int unsigned RESTART_CYCLES = 200
)
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       feedback_line_sense_pin,
   input oscc_sense_t     sense,
   input wire logic       gate,
   input oscc_limit_sel_t limit_sel,
   input wire logic       max_duty_signal,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic       s_axi_rvalid
);
   logic        mds_q;
   logic        per_ok;
   int unsigned per_cnt;
   wire         rise = max_duty_signal && !mds_q;

   // Period is measured only from the second cycle start on
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mds_q   <= 1'b0;
         per_ok  <= 1'b0;
         per_cnt <= 0;
      end else begin
         mds_q   <= max_duty_signal;
         per_ok  <= per_ok || rise;
         per_cnt <= rise ? 1 : per_cnt + 1;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   gate_needs_en_a: assert property (
      $rose(gate) |-> $past(feedback_line_sense_pin)
         && !$past(sense.supply_uv))
      else $error("gate rose without enable");
   gate_at_start_a: assert property ($rose(gate) |-> rise)
      else $error("gate rose away from cycle start");
   limit_ends_gate_a: assert property (
      gate && sense.cur_limit |=> !gate)
      else $error("gate survived current limit");
   gate_end_cause_a: assert property (
      $fell(gate) |-> $past(sense.cur_limit) || !$past(max_duty_signal))
      else $error("gate ended without cause");
   osc_rate_a: assert property (
      rise && per_ok |-> per_cnt ==
         ((limit_sel.level == OSCC_LIM_PEAK) ? 378 : 757))
      else $error("oscillator period wrong for level");
   // The output copy of the level trails the state machine by one clock
   level_at_edge_a: assert property (
      $changed(limit_sel.level) |-> $past(rise))
      else $error("limit level moved inside a cycle");
   cap_stable_a: assert property (
      gate |-> $stable(limit_sel.cap_set))
      else $error("limit set changed while switching");
   read_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");

   cover property (rise && limit_sel.level == OSCC_LIM_PEAK);
   cover property (rise && limit_sel.level == OSCC_LIM_LOW);
   cover property (gate && sense.cur_limit);
endmodule

bind oscc_ctrl oscc_ctrl_chk #(.RESTART_CYCLES(RESTART_CYCLES)) u_chk (
   .aclk, .aresetn, .feedback_line_sense_pin, .sense, .gate, .limit_sel,
   .max_duty_signal, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);

// >>> bench/oscc_fb_model.sv
`timescale 1ns/1ps
module oscc_fb_model #(
   parameter int unsigned REF = 2000
)
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       gate,
   input  wire logic [1:0] mode,
   output logic            en
);
   int unsigned vout;
   // Crude output store: conduction charges fast, load drains slowly
   always_ff @(posedge aclk) begin
      if (!aresetn)
         vout <= 0;
      else if (gate)
         vout <= vout + 4;
      else if (vout != 0)
         vout <= vout - 1;
   end
   // Mode 1 is an open loop, mode 2 a saturated output
   assign en = (mode == 2'd0) ? (vout < REF) : (mode == 2'd1);
endmodule

// >>> hw/oscc_ctrl.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "oscc_cfg.svh"
// Notes on behaviour
// R01: With extension on, gate stays on until current limit, ignoring duty end. Here a cycle start that samples enable low also ends it.
// R02: Extension off at startup and after restart, back on at regulation.
// R03: From power-up or restart hold, switching starts only above line threshold.
// R04: Power-up waits for line undervoltage clear and supply settled.
// R05: Once switching, line undervoltage is ignored until auto-restart.
// R06: Line undervoltage during restart hold freezes the restart counter.
// R07: Absent sense resistor disables the line undervoltage function.
// R08: Enabled cycle turns on at start, off at limit or duty end.
// R09: A started cycle completes regardless of enable changes.
// R10: Clock runs always; enable sampled each cycle start.
// R11: Highest limit level doubles oscillator rate; lower levels use standard.
// R12: More skipped cycles step limit to medium then lowest level.
// R13: Feedback holds enable high below reference, low above target.
// R14: On power-down, switch for fault interval then stay off while line low.
// R15: Capacitor size picks standard, reduced or increased limit set.
// R16: Low enable sample clears fault counter; full count enters auto-restart.
// R17: Auto-restart holds off, then alternates on and off until cleared.
// R18: Analog conditions arrive as synchronous single-bit inputs.
// R19: Limit level and rate kept in a state register, moved at cycle edges.
module oscc_ctrl
   import oscc_pkg::*;
#(
   parameter int unsigned RESTART_CYCLES = `OSCC_RESTART_CYCLES
)
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        feedback_line_sense_pin,
   input  oscc_sense_t      sense,  // see R18
   input  oscc_cap_t        supply_capacitor_pin,
   output logic             gate,
   output oscc_limit_sel_t  limit_sel,
   output logic             max_duty_signal,
   output logic             irq,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef enum logic [1:0] {
      OSCC_ST_POWERUP,
      OSCC_ST_RUN,
      OSCC_ST_HOLD,
      OSCC_ST_RETRY
   } oscc_state_t;

   oscc_state_t  state;
   oscc_state_t  next_state;
   oscc_limit_t  level;
   logic         double_rate;
   logic [9:0]   osc_cnt;
   logic [13:0]  fault_cnt;
   logic [26:0]  hold_cnt;
   logic         ext_en;
   logic         cycle_on;
   logic         run_sw;
   logic [31:0]  ctrl;
   logic [`OSCC_IRQ_W-1:0] irq_stat;
   logic [`OSCC_IRQ_W-1:0] irq_mask;
   logic [31:0]  cycle_total;
   logic [11:0]  aw_addr;
   logic         aw_held;
   logic [31:0]  w_data;
   logic [3:0]   w_strb;
   logic         w_held;

   function automatic logic [9:0] duty_of(input logic [9:0] period);
      duty_of = 10'((32'(period) * `OSCC_DUTY_PCT) / 100);
   endfunction

   // Oscillator period follows the limit level
   wire logic [9:0] period = double_rate ? 10'(`OSCC_PEAK_PERIOD)
                                         : 10'(`OSCC_STD_PERIOD);
   wire logic cycle_start = (osc_cnt == 10'h000);     // see R10
   wire logic cycle_end   = (osc_cnt == period - 10'h1);
   wire logic duty_on     = osc_cnt < duty_of(period);
   wire logic sample_en   = feedback_line_sense_pin;  // see R10
   wire logic sw_enable   = ctrl[`OSCC_CTRL_RUN_BIT];
   // Line undervoltage counts only if a sense resistor is fitted
   wire logic line_low    = sense.line_uv && !sense.res_absent; // see R07
   wire logic fault_full  = fault_cnt == 14'(`OSCC_FAULT_CYCLES - 1);
   wire logic hold_done   = hold_cnt == 27'(RESTART_CYCLES - 1);
   wire logic switching   = (state == OSCC_ST_RUN || state == OSCC_ST_RETRY);

   // State transitions on cycle boundaries only
   always_comb begin
      next_state = state;
      unique case (state)
         OSCC_ST_POWERUP: begin
            if (!line_low && !sense.supply_uv && sw_enable) begin
               next_state = OSCC_ST_RUN;  // see R03 see R04
            end
         end
         OSCC_ST_RUN, OSCC_ST_RETRY: begin
            // Line sense ignored while switching
            if (fault_full && sample_en) begin
               next_state = OSCC_ST_HOLD;  // see R05 see R16 see R14
            end else if (!sample_en && state == OSCC_ST_RETRY) begin
               next_state = OSCC_ST_RUN;   // see R17
            end
         end
         OSCC_ST_HOLD: begin
            if (hold_done && !line_low && !sense.supply_uv) begin
               next_state = OSCC_ST_RETRY;  // see R03 see R17
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_cnt <= 10'h000;
      end else begin
         osc_cnt <= cycle_end ? 10'h000 : osc_cnt + 10'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state     <= OSCC_ST_POWERUP;
         fault_cnt <= 14'h0000;
      end else if (cycle_start) begin
         state     <= next_state;
         // see R16
         fault_cnt <= (!sample_en || !switching) ? 14'h0000
                    : (fault_full ? fault_cnt : fault_cnt + 14'h1);
      end
   end

   // Restart hold timer freezes while the line is low
   always_ff @(posedge aclk) begin
      if (!aresetn || state != OSCC_ST_HOLD) begin
         hold_cnt <= 27'h0;
      end else if (!line_low && !hold_done) begin
         hold_cnt <= hold_cnt + 27'h1;  // see R06
      end
   end

   // Extension only after the output has been seen in regulation
   always_ff @(posedge aclk) begin
      if (!aresetn || !switching || state == OSCC_ST_RETRY) begin
         ext_en <= 1'b0;                    // see R02
      end else if (cycle_start && !sample_en) begin
         ext_en <= 1'b1;                    // see R02
      end
   end

   // Gate pulse: decided once per cycle; the enable input cuts only an extended pulse, at a cycle start
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cycle_on <= 1'b0;
      end else if (cycle_start) begin
         cycle_on <= switching && sample_en && !sense.supply_uv; // see R08 R09
      end else if (sense.cur_limit) begin
         cycle_on <= 1'b0;                  // see R08
      end else if (!sense.max_duty_signal && !ext_en) begin
         cycle_on <= 1'b0;                  // see R08 see R01
      end else if (cycle_end) begin
         cycle_on <= ext_en && cycle_on;    // see R01
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         max_duty_signal <= 1'b0;
         run_sw          <= 1'b0;
      end else begin
         max_duty_signal <= duty_on;
         run_sw          <= switching;
      end
   end

   assign gate = cycle_on;

   oscc_limit_fsm u_fsm (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .cycle_start (cycle_start && switching),
      .sample      (sample_en),
      .level       (level),
      .double_rate (double_rate)
   );

   // Limit set follows the capacitor straps while in power-up, held once the state leaves OSCC_ST_POWERUP
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         limit_sel <= '{OSCC_CAP_SMALL, OSCC_LIM_STD};
      end else begin
         if (state == OSCC_ST_POWERUP) begin
            limit_sel.cap_set <= supply_capacitor_pin;  // see R15
         end
         limit_sel.level <= level;                    // see R19 see R12
      end
   end

   // AXI4-Lite slave
   wire logic do_write = aw_held && w_held && !s_axi_bvalid;
   wire logic [`OSCC_IRQ_W-1:0] irq_ev = {
      state == OSCC_ST_HOLD && line_low,
      ext_en && cycle_start && !sample_en,
      next_state == OSCC_ST_HOLD && state != OSCC_ST_HOLD && cycle_start};
   wire logic wr_ctrl = do_write && aw_addr == `OSCC_CTRL_ADDR;
   wire logic wr_stat = do_write && aw_addr == `OSCC_IRQ_STAT_ADDR;
   wire logic wr_mask = do_write && aw_addr == `OSCC_IRQ_MASK_ADDR;
   wire logic aw_ok   = aw_addr == `OSCC_CTRL_ADDR
                     || aw_addr == `OSCC_IRQ_STAT_ADDR
                     || aw_addr == `OSCC_IRQ_MASK_ADDR;
   wire logic ar_ok   = s_axi_araddr[11:5] == 7'h0
                     && s_axi_araddr[4:2] <= 3'h4;
   wire logic [31:0] rd_mux =
        s_axi_araddr == `OSCC_CTRL_ADDR ? ctrl
      : s_axi_araddr == `OSCC_STAT_ADDR ?
           {24'h0, run_sw, ext_en, limit_sel.cap_set, limit_sel.level,
            state}
      : s_axi_araddr == `OSCC_IRQ_STAT_ADDR ? {29'h0, irq_stat}
      : s_axi_araddr == `OSCC_IRQ_MASK_ADDR ? {29'h0, irq_mask}
      : s_axi_araddr == `OSCC_CNT_ADDR ? cycle_total : 32'h0;

   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   assign s_axi_arready = !s_axi_rvalid;
   assign irq           = |(irq_stat & irq_mask);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 12'h000;
         w_data       <= 32'h0;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[11:2], 2'h0};
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= aw_ok ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= ar_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl        <= `OSCC_CTRL_RESET;
         irq_stat    <= '0;
         irq_mask    <= '0;
         cycle_total <= 32'h0;
      end else begin
         if (wr_ctrl && w_strb[0]) begin
            ctrl[7:0] <= w_data[7:0];
         end
         if (wr_mask && w_strb[0]) begin
            irq_mask <= w_data[`OSCC_IRQ_W-1:0];
         end
         irq_stat <= (irq_stat & ~(wr_stat && w_strb[0]
                     ? w_data[`OSCC_IRQ_W-1:0] : '0)) | irq_ev;
         if (cycle_start && cycle_on == 1'b0 && switching && sample_en) begin
            cycle_total <= cycle_total + 32'h1;
         end
      end
   end
endmodule

// >>> hw/oscc_limit_fsm.sv
`timescale 1ns/1ps
`include "oscc_cfg.svh"
module oscc_limit_fsm
   import oscc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        cycle_start,
   input  wire logic        sample,
   output oscc_limit_t      level,
   output logic             double_rate
);
   logic [3:0]  on_run;
   logic [3:0]  off_run;
   oscc_limit_t next_level;
   wire logic   run_full  = on_run >= 4'(`OSCC_PEAK_RUN - 1);
   wire logic   skip_low  = off_run >= 4'(`OSCC_SKIP_LOW - 1);
   wire logic   skip_med  = off_run >= 4'(`OSCC_SKIP_MED - 1);

   // Level moves only on a cycle boundary (see R19)
   always_comb begin
      next_level = level;
      if (sample && run_full) begin
         next_level = OSCC_LIM_PEAK;  // see R11
      end else if (!sample && skip_low) begin
         next_level = OSCC_LIM_LOW;   // see R12
      end else if (!sample && skip_med && level != OSCC_LIM_LOW) begin
         next_level = OSCC_LIM_MED;   // see R12
      end else if (sample && level == OSCC_LIM_PEAK) begin
         next_level = OSCC_LIM_PEAK;
      end else if (sample && on_run != 4'h0) begin
         next_level = OSCC_LIM_STD;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level   <= OSCC_LIM_STD;
         on_run  <= 4'h0;
         off_run <= 4'h0;
      end else if (cycle_start) begin
         level   <= next_level;
         on_run  <= sample ? (run_full ? on_run : on_run + 4'h1) : 4'h0;
         off_run <= sample ? 4'h0 : (skip_low ? off_run : off_run + 4'h1);
      end
   end

   assign double_rate = (level == OSCC_LIM_PEAK);  // see R11
endmodule

// >>> shared/oscc_cfg.svh
`ifndef OSCC_CFG_SVH
`define OSCC_CFG_SVH
// Register byte offsets
`define OSCC_CTRL_ADDR      12'h000
`define OSCC_STAT_ADDR      12'h004
`define OSCC_IRQ_STAT_ADDR  12'h008
`define OSCC_IRQ_MASK_ADDR  12'h00c
`define OSCC_CNT_ADDR       12'h010
// Control fields
`define OSCC_CTRL_RUN_BIT   0
`define OSCC_CTRL_CAP_LSB   1
`define OSCC_CTRL_RESET     32'h0000_0000
// Interrupt bits
`define OSCC_IRQ_RESTART    0
`define OSCC_IRQ_REGULATE   1
`define OSCC_IRQ_LINE_UV    2
`define OSCC_IRQ_W          3
// Clock 100 MHz; standard oscillator 132 kHz, peak 264 kHz
`define OSCC_CLK_HZ         100000000
`define OSCC_STD_HZ         132000
`define OSCC_STD_PERIOD     (`OSCC_CLK_HZ / `OSCC_STD_HZ)
`define OSCC_PEAK_PERIOD    (`OSCC_CLK_HZ / (2 * `OSCC_STD_HZ))
`define OSCC_DUTY_PCT       65
`define OSCC_FAULT_CYCLES   8192
`define OSCC_RESTART_OFF_MS 1000
`define OSCC_RESTART_CYCLES (`OSCC_RESTART_OFF_MS * 100000)
// Current-limit state machine thresholds, in consecutive samples
`define OSCC_PEAK_RUN       4
`define OSCC_SKIP_MED       2
`define OSCC_SKIP_LOW       6
`endif

// >>> shared/oscc_pkg.sv
package oscc_pkg;
   typedef enum logic [1:0] {
      OSCC_CAP_SMALL,
      OSCC_CAP_MID,
      OSCC_CAP_LARGE
   } oscc_cap_t;

   typedef enum logic [1:0] {
      OSCC_LIM_LOW,
      OSCC_LIM_MED,
      OSCC_LIM_STD,
      OSCC_LIM_PEAK
   } oscc_limit_t;

   typedef struct packed {
      logic cur_limit;
      logic max_duty_signal;
      logic line_uv;
      logic res_absent;
      logic supply_uv;
   } oscc_sense_t;

   typedef struct packed {
      oscc_cap_t   cap_set;
      oscc_limit_t level;
   } oscc_limit_sel_t;
endpackage
